// ===== core/ivm_mapper.sv
// Purpose: maps exception and interrupt sources to vector numbers and addresses
// Assumes: request lines are levels synchronous to core_clk; cpu pulses ack
// Notes:   level registers are written over a plain port, not a software bus
//          level value 31 parks a request; every level leaves reset parked
//          vector, level and address are held from the pick until the cpu acks
`timescale 1ns/100ps
`include "ivm_regs.svh"
module ivm_mapper (
    input  wire logic                   core_clk,
    input  wire logic                   arst_n,
    input  wire logic [3:0]             ext_irq,
    input  wire logic [1:0]             ext_irq_hi,
    input  wire logic [2:0]             uart_rx_done,
    input  wire logic [2:0]             uart_tx_done,
    input  wire logic [7:0]             dma_irq,
    input  wire logic                   adc_irq,
    input  wire logic [2:0]             reload_irq,
    input  wire logic [2:0]             utimer_irq,
    input  wire logic                   flash_irq,
    input  wire logic [3:0]             ppg_irq,
    input  wire logic [3:0]             icu_irq,
    input  wire logic [3:0]             ocu_irq,
    input  wire logic                   frt_irq,
    input  wire logic                   delay_irq,
    input  wire logic                   nmi_req,
    input  wire logic                   undef_exc,
    input  wire logic                   reset_exc,
    input  wire logic                   trap_req,
    input  wire ivm_pkg::ivm_vector_type trap_vct,
    input  wire logic                   table_base_we,
    input  wire logic [31:0]            table_base_wdata,
    input  wire logic                   lvl_we,
    input  wire logic [5:0]             lvl_idx,
    input  wire ivm_pkg::ivm_level_type lvl_wdata,
    input  wire logic                   cpu_ack,
    output logic                        irq_valid,
    output ivm_pkg::ivm_vector_type     irq_vct,
    output ivm_pkg::ivm_level_type      irq_level,
    output logic [31:0]                 irq_vctadr,
    output logic [31:0]                 table_base_out
);
    import ivm_pkg::*;

    // a level of 31 parks the request; kept in one place so gate and picker agree
    function automatic logic lvl_enabled(input ivm_level_type lv);
        return lv != `IVM_LVL_NONE;
    endfunction

    logic [31:0]      table_base_q;
    ivm_level_type    lvl_q [`IVM_NUM_LVL];
    ivm_state_type    state_q, state_d;
    logic             valid_q;
    ivm_vector_type   vct_q;
    ivm_level_type    level_q;
    logic [31:0]      adr_q;
    wire  [47:0]      req;
    wire  [47:0]      live;
    wire  [47:0]      lvl_hit;
    wire  [31:0]      sel_adr;
    ivm_vector_type   sel_vct;
    ivm_level_type    sel_lvl;
    logic             sel_any;

    // source map by level index (vector = index + 16):
    //   0..3   external lines 0..3
    //   4..6   uart receive complete 0..2
    //   7..9   uart transmit complete 0..2
    //   10..17 dma channels 0..7
    //   18     converter done
    //   19..21 reload timers 0..2
    //   22..23 external lines 4..5
    //   24..25 held for system use, tied low
    //   26..28 baud timers 0..2
    //   29     flash
    //   30..31 held for system use, tied low
    //   32..35 pulse generators 0..3
    //   36..39 capture units 0..3
    //   40..43 compare units 0..3
    //   44     held, tied low
    //   45     free-running timer
    //   46     held, tied low
    //   47     delayed cause bit
    // an unused slot still owns a level register, so the map stays regular
    // request lines by level index; vector is index plus 16
    assign req = {delay_irq, 1'b0, frt_irq, 1'b0,            // 47..44
                  ocu_irq, icu_irq, ppg_irq,                 // 43..32
                  2'b00, flash_irq, utimer_irq, 2'b00,       // 31..24
                  ext_irq_hi, reload_irq, adc_irq, dma_irq,  // 23..10
                  uart_tx_done, uart_rx_done, ext_irq};      // 9..0

    // level 31 means disabled, so such a request never reaches the cpu
    genvar gi;
    generate
        for (gi = 0; gi < `IVM_NUM_LVL; gi++) begin : g_live
            assign live[gi] = req[gi] && lvl_enabled(lvl_q[gi]);
        end
    endgenerate

    // one-hot write select, so each level flop sees a plain enable
    generate
        for (gi = 0; gi < `IVM_NUM_LVL; gi++) begin : g_hit
            assign lvl_hit[gi] = lvl_we && (lvl_idx == 6'(gi));
        end
    endgenerate

    // priority, highest first:
    //   reset, undefined instruction, nmi at its fixed level,
    //   maskable requests by lowest level value, ties to the lowest vector,
    //   software trap with a vector of 66 or more
    // vectors 64 and 65 are refused as traps; they stay with kernel code
    // selection: exceptions first, then nmi, then lowest level value wins
    always_comb begin
        sel_any = 1'b1;
        sel_vct = `IVM_VEC_RESET;
        sel_lvl = `IVM_LVL_NMI;
        if (reset_exc) begin
            sel_vct = `IVM_VEC_RESET;
        end else if (undef_exc) begin
            sel_vct = `IVM_VEC_UNDEF;
        end else if (nmi_req) begin
            sel_vct = `IVM_VEC_NMI;
            sel_lvl = `IVM_LVL_NMI;
        end else if (|live) begin
            sel_lvl = `IVM_LVL_NONE;
            for (int i = `IVM_NUM_LVL - 1; i >= 0; i--) begin
                if (live[i] && lvl_q[i] <= sel_lvl) begin
                    sel_lvl = lvl_q[i];
                    sel_vct = `IVM_VEC_MASK_FIRST + 8'(i);
                end
            end
        end else if (trap_req && trap_vct >= `IVM_VEC_TRAP_FIRST) begin
            sel_vct = trap_vct;
            sel_lvl = `IVM_LVL_NONE;
        end else begin
            sel_any = 1'b0;
        end
    end

    ivm_vec_addr u_addr (
        .table_base (table_base_q),
        .vct    (sel_vct),
        .vctadr (sel_adr)
    );

    // handshake timing: the pick is taken at an idle edge, valid rises at that same
    // edge, the edge that sees ack drops it, and one idle cycle follows so a
    // source still high just after ack is not taken twice
    // limitation: sources are levels and must drop within that idle cycle
    // state: idle, presenting, one fixed cycle after ack for the request to drop
    always_comb begin
        case (state_q)
            IVM_IDLE: state_d = sel_any ? IVM_PEND : IVM_IDLE;
            IVM_PEND: state_d = cpu_ack ? IVM_ACK : IVM_PEND;
            IVM_ACK:  state_d = IVM_IDLE;
            default:  state_d = IVM_IDLE;
        endcase
    end

    // table base; low two bits kept zero so entries stay word aligned
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            table_base_q <= `IVM_TABLE_BASE_RESET;
        end else if (table_base_we) begin
            table_base_q <= {table_base_wdata[31:2], 2'b00};
        end
    end

    // level registers, one per maskable request
    generate
        for (gi = 0; gi < `IVM_NUM_LVL; gi++) begin : g_lvl
            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    lvl_q[gi] <= `IVM_LVL_RESET;
                end else if (lvl_hit[gi]) begin
                    lvl_q[gi] <= lvl_wdata;
                end
            end
        end
    endgenerate

    // presented vector is frozen while pending so the cpu sees one stable fetch
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= IVM_IDLE;
            valid_q <= 1'b0;
            vct_q   <= `IVM_VEC_RESET;
            level_q <= `IVM_LVL_NONE;
            adr_q   <= `IVM_TABLE_BASE_RESET;
        end else begin
            state_q <= state_d;
            valid_q <= (state_d == IVM_PEND);
            if (state_q == IVM_IDLE && sel_any) begin
                vct_q   <= sel_vct;
                level_q <= sel_lvl;
                adr_q   <= sel_adr;
            end
        end
    end

    assign irq_valid  = valid_q;
    assign irq_vct    = vct_q;
    assign irq_level  = level_q;
    // outputs come straight from flops; the address is captured with the vector
    // so a later table base write cannot tear a fetch already presented
    assign irq_vctadr = adr_q;
    assign table_base_out = table_base_q;
endmodule

// ===== core/ivm_pkg.sv
// Purpose: shared types for the interrupt vector mapper
// Assumes: nothing
// Notes:   states of the request presentation machine
package ivm_pkg;
    typedef enum logic [2:0] {
        IVM_IDLE = 3'b001,
        IVM_PEND = 3'b010,
        IVM_ACK  = 3'b100
    } ivm_state_type;
    typedef logic [4:0] ivm_level_type;
    typedef logic [7:0] ivm_vector_type;
endpackage

// ===== core/ivm_regs.svh
// Purpose: constants for the interrupt vector mapper
// Assumes: included by bare name from core files
// Notes:   vector numbers, offsets and reset values of the vector table
`ifndef IVM_REGS_SVH
`define IVM_REGS_SVH

`define IVM_TABLE_BASE_RESET 32'h000FFC00
`define IVM_VEC_OFS_TOP    10'h3FC
`define IVM_VEC_AREA_BYTES 11'h400
`define IVM_VEC_RESET      8'h00
`define IVM_VEC_UNDEF      8'h0E
`define IVM_VEC_NMI        8'h0F
`define IVM_LVL_NMI        5'h0F
`define IVM_VEC_MASK_FIRST 8'h10
`define IVM_VEC_MASK_LAST  8'h3F
`define IVM_VEC_OS0        8'h40
`define IVM_VEC_OS1        8'h41
`define IVM_VEC_TRAP_FIRST 8'h42
`define IVM_NUM_LVL        48
`define IVM_LVL_RESET      5'h1F
`define IVM_LVL_NONE       5'h1F
`define IVM_IDX_UART_RX0   4
`define IVM_IDX_UART_TX0   7
`define IVM_IDX_FRT        45
`define IVM_IDX_DLY        47

`endif

// ===== core/ivm_vec_addr.sv
// Purpose: forms the vector fetch address from table base and vector number
// Assumes: table base is word aligned
// Notes:   purely combinational, used by the mapper top
`timescale 1ns/100ps
`include "ivm_regs.svh"
module ivm_vec_addr (
    input  wire logic [31:0]              table_base,
    input  wire ivm_pkg::ivm_vector_type  vct,
    output logic      [31:0]              vctadr
);
    import ivm_pkg::*;
    wire [9:0]  vct_ofs;
    wire [31:0] sum;

    // offset counts down from the top entry; 8-bit vector keeps it inside 1 KB
    assign vct_ofs = `IVM_VEC_OFS_TOP - {vct, 2'b00};
    assign sum     = table_base + {22'h000000, vct_ofs};
    assign vctadr  = sum;
endmodule

// ===== test/ivm_cpu_model.sv
// Purpose: cpu side that takes presented vectors
// Assumes: one clock, async reset
// Notes:   ack delay set by slow, so prompt and late takes both occur
`timescale 1ns/100ps
module ivm_cpu_model (
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic [1:0] slow,
    input  wire logic       irq_valid,
    output logic            cpu_ack
);
    logic [1:0] wait_q;
    // one ack pulse per vector, after slow waiting cycles
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_ack <= 1'b0;
            wait_q  <= 2'h0;
        end else begin
            cpu_ack <= irq_valid && !cpu_ack && wait_q == slow;
            wait_q  <= (irq_valid && !cpu_ack && wait_q != slow) ? wait_q + 2'h1 : 2'h0;
        end
    end
endmodule

// ===== test/ivm_mapper_props.sv
// Purpose: port checks for the vector mapper
// Assumes: cpu pulses ack for one cycle
// Notes:   table base is not rewritten while a vector stands
`timescale 1ns/100ps
module ivm_mapper_props (
    input wire logic                    core_clk,
    input wire logic                    arst_n,
    input wire logic                    reset_exc,
    input wire logic                    nmi_req,
    input wire logic                    cpu_ack,
    input wire logic                    irq_valid,
    input wire ivm_pkg::ivm_vector_type irq_vct,
    input wire ivm_pkg::ivm_level_type  irq_level,
    input wire logic [31:0]             irq_vctadr,
    input wire logic [31:0]             table_base_out
);
    import ivm_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // address, vector and level tie to their cause, not to a copy of one flop
    a_addr_formula: assert property (
        irq_valid |-> irq_vctadr == table_base_out + 32'h3FC - {22'h0, irq_vct, 2'b00})
        else $error("vector address wrong");
    a_hold_vector: assert property (
        irq_valid && !cpu_ack |=> irq_valid && $stable(irq_vct) && $stable(irq_vctadr))
        else $error("vector changed before ack");
    a_ack_drop: assert property (irq_valid && cpu_ack |=> !irq_valid ##1 !irq_valid)
        else $error("valid not dropped after ack");
    a_nmi_level: assert property (irq_valid && irq_vct == 8'h0F |-> irq_level == 5'h0F)
        else $error("nmi level not fixed");
    a_reset_first: assert property ($rose(irq_valid) && $past(reset_exc) |-> irq_vct == 8'h00)
        else $error("reset vector lost priority");
    a_nmi_vector: assert property (
        $rose(irq_valid) && $past(nmi_req) && !$past(reset_exc) |-> irq_vct inside {8'h0E, 8'h0F})
        else $error("nmi vector wrong");
    a_base_reset: assert property ($rose(arst_n) |-> table_base_out == 32'h000FFC00)
        else $error("table base reset wrong");
    a_mask_level: assert property (
        irq_valid && irq_vct inside {[8'h10:8'h3F]} |-> irq_level != 5'h1F)
        else $error("disabled level presented");
endmodule
bind ivm_mapper ivm_mapper_props u_props (.core_clk(core_clk), .arst_n(arst_n),
    .reset_exc(reset_exc), .nmi_req(nmi_req), .cpu_ack(cpu_ack), .irq_valid(irq_valid),
    .irq_vct(irq_vct), .irq_level(irq_level), .irq_vctadr(irq_vctadr),
    .table_base_out(table_base_out));

// ===== test/tb_ivm_mapper.sv
// Purpose: self-checking bench for the vector mapper
// Assumes: cpu model acks every vector
// Notes:   sources sit in one word indexed by vector number
`timescale 1ns/100ps
module tb_ivm_mapper;
    import ivm_pkg::*;
    logic           core_clk, arst_n, table_base_we, lvl_we, trap_req, irq_valid, cpu_ack;
    logic [63:0]    src;
    logic [31:0]    table_base_wdata, irq_vctadr, table_base_out, base;
    logic [5:0]     lvl_idx;
    logic [1:0]     slow;
    ivm_level_type  lvl_wdata, irq_level;
    ivm_vector_type trap_vct, irq_vct;
    int             errors = 0, cmp_count = 0, cyc = 0;
    logic [7:0]     rows [11] = '{0, 14, 15, 16, 20, 23, 25, 33, 45, 61, 63};
    ivm_mapper dut_u (.core_clk(core_clk), .arst_n(arst_n), .ext_irq(src[19:16]),
        .ext_irq_hi(src[39:38]), .uart_rx_done(src[22:20]), .uart_tx_done(src[25:23]),
        .dma_irq(src[33:26]), .adc_irq(src[34]), .reload_irq(src[37:35]),
        .utimer_irq(src[44:42]), .flash_irq(src[45]), .ppg_irq(src[51:48]),
        .icu_irq(src[55:52]), .ocu_irq(src[59:56]), .frt_irq(src[61]), .delay_irq(src[63]),
        .nmi_req(src[15]), .undef_exc(src[14]), .reset_exc(src[0]), .trap_req(trap_req),
        .trap_vct(trap_vct), .table_base_we(table_base_we),
        .table_base_wdata(table_base_wdata), .lvl_we(lvl_we),
        .lvl_idx(lvl_idx), .lvl_wdata(lvl_wdata), .cpu_ack(cpu_ack), .irq_valid(irq_valid),
        .irq_vct(irq_vct), .irq_level(irq_level), .irq_vctadr(irq_vctadr),
        .table_base_out(table_base_out));
    ivm_cpu_model cpu_u (.core_clk(core_clk), .arst_n(arst_n), .slow(slow),
        .irq_valid(irq_valid), .cpu_ack(cpu_ack));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // raise sources, wait for the vector, check it, then drop sources
    task automatic go(input logic [63:0] s, input logic [7:0] v, input logic [4:0] lv);
        @(posedge core_clk);
        src <= s;
        repeat (20) if (irq_valid !== 1'b1) @(negedge core_clk);
        chk("vector", {24'h0, v}, {24'h0, irq_vct});
        chk("address", base + 32'h3FC - {22'h0, v, 2'b00}, irq_vctadr);
        if (lv != 5'h1F) chk("level", {27'h0, lv}, {27'h0, irq_level});
        @(posedge core_clk);
        src <= 64'h0;
        trap_req <= 1'b0;
        repeat (20) if (irq_valid !== 1'b0) @(negedge core_clk);
    endtask
    // a refused request must show no vector at the sixth falling edge after it is raised
    task automatic quiet(input logic [63:0] s);
        @(posedge core_clk);
        src <= s;
        repeat (6) @(negedge core_clk);
        chk("refused", 32'h0, {31'h0, irq_valid});
        @(posedge core_clk);
        src <= 64'h0;
        trap_req <= 1'b0;
    endtask
    task automatic lvl(input int i, input logic [4:0] d);
        @(posedge core_clk);
        lvl_we <= 1'b1;
        lvl_idx <= 6'(i);
        lvl_wdata <= d;
        @(posedge core_clk);
        lvl_we <= 1'b0;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        {arst_n, table_base_we, lvl_we, trap_req, src, slow} = '0;
        {table_base_wdata, lvl_idx, lvl_wdata, trap_vct} = '0;
        base = 32'h000FFC00;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        @(negedge core_clk);
        chk("base", base, table_base_out);
        for (int i = 0; i < 48; i++) lvl(i, 5'(i % 15));
        foreach (rows[k]) begin
            slow <= 2'(k);
            go(64'h1 << rows[k], rows[k], rows[k] == 15 ? 5'h0F :
                rows[k] < 16 ? 5'h1F : 5'((rows[k] - 16) % 15));
        end
        $display("table rows done");
        go(64'h0010C001, 8'h00, 5'h1F);
        go(64'h0010C000, 8'h0E, 5'h1F);
        go(64'h00108000, 8'h0F, 5'h0F);
        go(64'h00300000, 8'h14, 5'h04);
        lvl(45, 5'h1F);
        quiet(64'h1 << 61);
        @(posedge core_clk);
        trap_req <= 1'b1;
        trap_vct <= 8'h41;
        quiet(64'h0);
        for (int t = 0; t < 2; t++) begin
            @(posedge core_clk);
            trap_req <= 1'b1;
            trap_vct <= t ? 8'hFF : 8'h42;
            go(64'h0, t ? 8'hFF : 8'h42, 5'h1F);
        end
        $display("priority and refusal done");
        @(posedge core_clk);
        table_base_we <= 1'b1;
        table_base_wdata <= 32'h00012347;
        @(posedge core_clk);
        table_base_we <= 1'b0;
        base = 32'h00012344;
        @(negedge core_clk);
        chk("base", base, table_base_out);
        go(64'h1 << 63, 8'h3F, 5'h02);
        @(posedge core_clk);
        arst_n <= 1'b0;
        @(posedge core_clk);
        arst_n <= 1'b1;
        base = 32'h000FFC00;
        @(negedge core_clk);
        chk("base", base, table_base_out);
        quiet(64'h1 << 20);
        $display("base write and reset done");
        wrap_up();
    end
endmodule
